//--- rtl/lsgb_pkg.sv
// package: register map, reset values and bus carriers of the shared gpio banks
package lsgb_pkg;

    // ****************************************************
    // widths
    // ****************************************************
    localparam int LSGB_ADDR_W = 12;
    localparam int LSGB_DATA_W = 32;
    localparam int LSGB_F_PINS = 8;
    localparam int LSGB_G_PINS = 6;
    localparam int LSGB_PINS = LSGB_F_PINS + LSGB_G_PINS;
    localparam int LSGB_SEG_BASE = 28;
    localparam int LSGB_SEN_BASE = 24;

    // ****************************************************
    // register indices and byte addresses
    // ****************************************************
    localparam logic [9:0] LSGB_IDX_DIR_F = 10'h185;
    localparam logic [9:0] LSGB_IDX_DIR_G = 10'h187;
    localparam logic [9:0] LSGB_IDX_LVL_F = 10'h188;
    localparam logic [9:0] LSGB_IDX_LVL_G = 10'h189;
    localparam logic [9:0] LSGB_IDX_SEN_24 = 10'h19c;
    localparam logic [9:0] LSGB_IDX_SEN_32 = 10'h19d;
    localparam logic [9:0] LSGB_IDX_SEN_40 = 10'h19e;

    localparam logic [LSGB_ADDR_W-1:0] LSGB_ADDR_DIR_F = {LSGB_IDX_DIR_F, 2'b00};
    localparam logic [LSGB_ADDR_W-1:0] LSGB_ADDR_DIR_G = {LSGB_IDX_DIR_G, 2'b00};
    localparam logic [LSGB_ADDR_W-1:0] LSGB_ADDR_LVL_F = {LSGB_IDX_LVL_F, 2'b00};
    localparam logic [LSGB_ADDR_W-1:0] LSGB_ADDR_LVL_G = {LSGB_IDX_LVL_G, 2'b00};
    localparam logic [LSGB_ADDR_W-1:0] LSGB_ADDR_SEN_24 = {LSGB_IDX_SEN_24, 2'b00};
    localparam logic [LSGB_ADDR_W-1:0] LSGB_ADDR_SEN_32 = {LSGB_IDX_SEN_32, 2'b00};
    localparam logic [LSGB_ADDR_W-1:0] LSGB_ADDR_SEN_40 = {LSGB_IDX_SEN_40, 2'b00};

    // ****************************************************
    // reset values
    // ****************************************************
    localparam logic [7:0] LSGB_RST_DIR_F = 8'hff;
    localparam logic [5:0] LSGB_RST_DIR_G = 6'h3f;
    localparam logic [7:0] LSGB_RST_LVL_F = 8'h00;
    localparam logic [5:0] LSGB_RST_LVL_G = 6'h00;
    localparam logic [7:0] LSGB_RST_SEN = 8'h00;
    localparam logic [1:0] LSGB_RST_SEN_40 = 2'h0;
    localparam logic [LSGB_DATA_W-1:0] LSGB_ZERO_WORD = 32'h0000_0000;

    // ****************************************************
    // bus carriers
    // ****************************************************
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [LSGB_ADDR_W-1:0] paddr;
        logic [LSGB_DATA_W-1:0] pwdata;
    } lsgb_apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [LSGB_DATA_W-1:0] prdata;
    } lsgb_apb_rsp_t;

    typedef struct packed {
        logic [LSGB_PINS-1:0] level;
        logic [LSGB_PINS-1:0] floatSeg;
    } lsgb_seg_drive_t;

endpackage

//--- rtl/lsgb_pin_mux.sv
// module: one shared pin, choosing between segment drive and port latch
`timescale 1ns/100ps
`default_nettype none
module lsgb_pin_mux
(
    input wire logic segOwn,
    input wire logic segLevel,
    input wire logic segFloat,
    input wire logic latchBit,
    input wire logic dirBit,
    output logic padLevel,
    output logic padOeN
);

    // ****************************************************
    // pin ownership
    // ****************************************************
    always_comb
    begin
        if (segOwn)
        begin
            padLevel = segLevel;
            padOeN = segFloat;
        end
        else
        begin
            padLevel = latchBit;
            padOeN = dirBit;
        end
    end

endmodule
`default_nettype wire

//--- rtl/lsgb_banks.sv
// module: two gpio banks sharing their pins with lcd segment outputs, apb slave
`timescale 1ns/100ps
`default_nettype none

module lsgb_banks
    import lsgb_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic otherReset,
    input wire lsgb_apb_req_t apbReq,
    output lsgb_apb_rsp_t apbRsp,
    input wire logic lcdModuleEnable,
    input wire lsgb_seg_drive_t lcdSegmentOutput,
    input wire logic [LSGB_F_PINS-1:0] bankFPinsIn,
    output logic [LSGB_F_PINS-1:0] bankFPinsOut,
    output logic [LSGB_F_PINS-1:0] bankFPinsOeN,
    input wire logic [LSGB_G_PINS-1:0] bankGPinsIn,
    output logic [LSGB_G_PINS-1:0] bankGPinsOut,
    output logic [LSGB_G_PINS-1:0] bankGPinsOeN
);

    // ****************************************************
    // state
    // ****************************************************
    typedef struct packed {
        logic [7:0] dirF;
        logic [5:0] dirG;
        logic [7:0] latchF;
        logic [5:0] latchG;
        logic [7:0] segEn24;
        logic [7:0] segEn32;
        logic [1:0] segEn40;
        logic pready;
        logic pslverr;
        logic [LSGB_DATA_W-1:0] prdata;
        logic [LSGB_PINS-1:0] padOut;
        logic [LSGB_PINS-1:0] padOeN;
    } lsgb_state_t;

    lsgb_state_t state_reg;
    lsgb_state_t state_next;

    // ****************************************************
    // pin view
    // ****************************************************
    logic [LSGB_PINS-1:0] allLatch;
    logic [LSGB_PINS-1:0] allDir;
    logic [17:0] segEnAll;
    logic [LSGB_PINS-1:0] segOwn;
    logic [LSGB_PINS-1:0] muxLevel;
    logic [LSGB_PINS-1:0] muxOeN;

    assign allLatch = {state_reg.latchG, state_reg.latchF};
    assign allDir = {state_reg.dirG, state_reg.dirF};
    assign segEnAll = {state_reg.segEn40, state_reg.segEn32, state_reg.segEn24};

    // ****************************************************
    // per pin segment map and ownership
    // ****************************************************
    genvar p;
    generate
        for (p = 0; p < LSGB_PINS; p = p + 1)
        begin : gPin
            // segment number on this pin, counted from the segment base
            localparam int SEG_IDX = (p < 4) ? p + 4 : ((p < 8) ? p - 4 : p);
            localparam int EN_IDX = SEG_IDX + LSGB_SEG_BASE - LSGB_SEN_BASE;

            assign segOwn[p] = lcdModuleEnable & segEnAll[EN_IDX];

            lsgb_pin_mux uMux
            (
                .segOwn(segOwn[p]),
                .segLevel(lcdSegmentOutput.level[SEG_IDX]),
                .segFloat(lcdSegmentOutput.floatSeg[SEG_IDX]),
                .latchBit(allLatch[p]),
                .dirBit(allDir[p]),
                .padLevel(muxLevel[p]),
                .padOeN(muxOeN[p])
            );
        end
    endgenerate

    // ****************************************************
    // bus phases
    // ****************************************************
    logic setupPhase;
    logic commitWrite;

    assign setupPhase = apbReq.psel & ~apbReq.penable;
    assign commitWrite = apbReq.psel & apbReq.penable & state_reg.pready & apbReq.pwrite & ~state_reg.pslverr;

    // ****************************************************
    // next state
    // ****************************************************
    always_comb
    begin
        state_next = state_reg;
        state_next.pready = 1'b0;
        state_next.pslverr = 1'b0;
        state_next.prdata = LSGB_ZERO_WORD;

        // answer is prepared in the setup cycle, pready stands in access
        if (setupPhase)
        begin
            state_next.pready = 1'b1;
            case (apbReq.paddr)
                LSGB_ADDR_DIR_F:
                begin
                    state_next.prdata = {24'h00_0000, state_reg.dirF};
                end
                LSGB_ADDR_DIR_G:
                begin
                    state_next.prdata = {26'h000_0000, state_reg.dirG};
                end
                LSGB_ADDR_LVL_F:
                begin
                    state_next.prdata = {24'h00_0000, bankFPinsIn};
                end
                LSGB_ADDR_LVL_G:
                begin
                    state_next.prdata = {26'h000_0000, bankGPinsIn};
                end
                LSGB_ADDR_SEN_24:
                begin
                    state_next.prdata = {24'h00_0000, state_reg.segEn24};
                end
                LSGB_ADDR_SEN_32:
                begin
                    state_next.prdata = {24'h00_0000, state_reg.segEn32};
                end
                LSGB_ADDR_SEN_40:
                begin
                    state_next.prdata = {30'h0000_0000, state_reg.segEn40};
                end
                default:
                begin
                    state_next.pslverr = 1'b1;
                end
            endcase
        end

        // write takes effect at the completing edge only
        if (commitWrite)
        begin
            case (apbReq.paddr)
                LSGB_ADDR_DIR_F:
                begin
                    state_next.dirF = apbReq.pwdata[7:0];
                end
                LSGB_ADDR_DIR_G:
                begin
                    state_next.dirG = apbReq.pwdata[5:0];
                end
                LSGB_ADDR_LVL_F:
                begin
                    state_next.latchF = apbReq.pwdata[7:0];
                end
                LSGB_ADDR_LVL_G:
                begin
                    state_next.latchG = apbReq.pwdata[5:0];
                end
                LSGB_ADDR_SEN_24:
                begin
                    state_next.segEn24 = apbReq.pwdata[7:0];
                end
                LSGB_ADDR_SEN_32:
                begin
                    state_next.segEn32 = apbReq.pwdata[7:0];
                end
                LSGB_ADDR_SEN_40:
                begin
                    state_next.segEn40 = apbReq.pwdata[1:0];
                end
                default:
                begin
                end
            endcase
        end

        // other resets touch only the directions; latches and enables stay
        if (otherReset)
        begin
            state_next.dirF = LSGB_RST_DIR_F;
            state_next.dirG = LSGB_RST_DIR_G;
        end

        state_next.padOut = muxLevel;
        state_next.padOeN = muxOeN;
        if (otherReset)
        begin
            // pins fall back to inputs unless a segment owns them
            state_next.padOeN = muxOeN | ~segOwn;
        end
    end

    // ****************************************************
    // registers
    // ****************************************************
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg.dirF <= LSGB_RST_DIR_F;
            state_reg.dirG <= LSGB_RST_DIR_G;
            state_reg.latchF <= LSGB_RST_LVL_F;
            state_reg.latchG <= LSGB_RST_LVL_G;
            state_reg.segEn24 <= LSGB_RST_SEN;
            state_reg.segEn32 <= LSGB_RST_SEN;
            state_reg.segEn40 <= LSGB_RST_SEN_40;
            state_reg.pready <= 1'b0;
            state_reg.pslverr <= 1'b0;
            state_reg.prdata <= LSGB_ZERO_WORD;
            state_reg.padOut <= '0;
            state_reg.padOeN <= '1;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // ****************************************************
    // outputs
    // ****************************************************
    assign apbRsp.pready = state_reg.pready;
    assign apbRsp.pslverr = state_reg.pslverr;
    assign apbRsp.prdata = state_reg.prdata;
    assign bankFPinsOut = state_reg.padOut[LSGB_F_PINS-1:0];
    assign bankFPinsOeN = state_reg.padOeN[LSGB_F_PINS-1:0];
    assign bankGPinsOut = state_reg.padOut[LSGB_PINS-1:LSGB_F_PINS];
    assign bankGPinsOeN = state_reg.padOeN[LSGB_PINS-1:LSGB_F_PINS];

endmodule
`default_nettype wire

//--- verif/lsgb_banks_monitor.sv
// checker: bus timing, read fields and reset reach of the gpio banks
`timescale 1ns/100ps
`default_nettype none
module lsgb_banks_monitor
    import lsgb_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic otherReset,
    input wire lsgb_apb_req_t apbReq,
    input wire lsgb_apb_rsp_t apbRsp,
    input wire logic lcdModuleEnable,
    input wire logic [LSGB_F_PINS-1:0] bankFPinsIn,
    input wire logic [LSGB_F_PINS-1:0] bankFPinsOeN,
    input wire logic [LSGB_G_PINS-1:0] bankGPinsOeN
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    sequence s_setup;
        apbReq.psel && !apbReq.penable;
    endsequence
    sequence s_rd_dir_g;
        s_setup ##1 (apbRsp.pready && !apbReq.pwrite && apbReq.paddr == LSGB_ADDR_DIR_G);
    endsequence
    sequence s_rd_lvl_g;
        s_setup ##1 (apbRsp.pready && !apbReq.pwrite && apbReq.paddr == LSGB_ADDR_LVL_G);
    endsequence
    a_ready_after_setup: assert property (s_setup |=> apbRsp.pready) else $error("no ready after setup");
    a_ready_one_cycle: assert property (apbRsp.pready |=> !apbRsp.pready) else $error("ready held");
    a_no_stray_ready: assert property (!(apbReq.psel && !apbReq.penable) |=> !apbRsp.pready)
        else $error("ready without setup");
    a_rdata_idle_zero: assert property (!apbRsp.pready |-> apbRsp.prdata == '0) else $error("data outside access");
    a_err_misaligned: assert property (s_setup ##0 apbReq.paddr[1:0] != 2'b00 |=> apbRsp.pslverr)
        else $error("misaligned not refused");
    a_dir_g_upper: assert property (s_rd_dir_g |-> apbRsp.prdata[31:6] == '0) else $error("dir g upper");
    a_lvl_g_upper: assert property (s_rd_lvl_g |-> apbRsp.prdata[31:6] == '0) else $error("level g upper");
    a_lvl_reads_pin: assert property (apbReq.psel && !apbReq.penable && !apbReq.pwrite &&
        apbReq.paddr == LSGB_ADDR_LVL_F |=> apbRsp.prdata[7:0] == $past(bankFPinsIn)) else $error("level f read");
    a_other_inputs: assert property (otherReset && !lcdModuleEnable |=> bankFPinsOeN == '1 &&
        bankGPinsOeN == '1) else $error("pins not inputs");
endmodule
bind lsgb_banks lsgb_banks_monitor lsgb_banks_monitor_inst (.clk, .rst, .otherReset, .apbReq, .apbRsp,
    .lcdModuleEnable, .bankFPinsIn, .bankFPinsOeN, .bankGPinsOeN);
`default_nettype wire

//--- verif/lsgb_pin_model.sv
// model: pads of both banks, outside device driving the released pins
`timescale 1ns/100ps
`default_nettype none
module lsgb_pin_model
#(
    parameter logic [7:0] EXT_F = 8'h5c,
    parameter logic [5:0] EXT_G = 6'h13
)
(
    input wire logic [7:0] fOut,
    input wire logic [7:0] fOeN,
    input wire logic [5:0] gOut,
    input wire logic [5:0] gOeN,
    output logic [7:0] fIn,
    output logic [5:0] gIn
);
    // driven pad reads its own level, released pad the outside one
    assign fIn = (fOut & ~fOeN) | (EXT_F & fOeN);
    assign gIn = (gOut & ~gOeN) | (EXT_G & gOeN);
endmodule
`default_nettype wire

//--- verif/lsgb_banks_tb.sv
// testbench: register access, pin ownership and reset kinds of the gpio banks
`timescale 1ns/100ps
`default_nettype none
module lsgb_banks_tb
    import lsgb_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic otherReset = 1'b0;
    logic lcd_module_enable = 1'b0;
    lsgb_apb_req_t req = '0;
    lsgb_apb_rsp_t rsp;
    lsgb_seg_drive_t seg = '0;
    logic [7:0] fIn, fOut, fOeN;
    logic [5:0] gIn, gOut, gOeN;
    logic [31:0] rd;
    logic er;
    int nMismatch = 0;
    int cmpCount = 0;
    int cyc = 0;

    always #2.5 clk = ~clk;

    lsgb_banks lsgb_banks_inst (.clk, .rst, .otherReset, .apbReq(req), .apbRsp(rsp), .lcdModuleEnable(lcd_module_enable),
        .lcdSegmentOutput(seg), .bankFPinsIn(fIn), .bankFPinsOut(fOut), .bankFPinsOeN(fOeN),
        .bankGPinsIn(gIn), .bankGPinsOut(gOut), .bankGPinsOeN(gOeN));
    lsgb_pin_model lsgb_pin_model_inst (.fOut, .fOeN, .gOut, .gOeN, .fIn, .gIn);

    task automatic closeOut();
        $display("compares %0d mismatches %0d", cmpCount, nMismatch);
        if (nMismatch == 0 && cmpCount > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            nMismatch = nMismatch + 1;
            closeOut();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmpCount++;
        if (seen !== exp)
        begin
            nMismatch++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // idle edge first, so a released request is never re-driven in one step
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk);
        req.penable <= 1'b1;
        do
            @(posedge clk);
        while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        er = rsp.pslverr;
        req <= '0;
    endtask

    task automatic rc(input logic [11:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0000_0000);
        chk(rd, e);
    endtask

    initial
    begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rc(LSGB_ADDR_DIR_F, 32'h0000_00ff);
        rc(LSGB_ADDR_DIR_G, 32'h0000_003f);
        rc(LSGB_ADDR_SEN_24, 32'h0000_0000);
        rc(LSGB_ADDR_SEN_32, 32'h0000_0000);
        chk(32'({fOeN, gOeN}), 32'h0000_3fff);
        xfer(1'b0, 12'h618, 32'h0000_0000);
        chk(32'(er), 32'h0000_0001);
        xfer(1'b1, 12'h615, 32'h0000_0000);
        chk(32'(er), 32'h0000_0001);
        xfer(1'b1, LSGB_ADDR_DIR_F, 32'h0000_000f);
        xfer(1'b1, LSGB_ADDR_LVL_F, 32'h0000_00a5);
        xfer(1'b1, LSGB_ADDR_DIR_G, 32'hffff_ff15);
        xfer(1'b1, LSGB_ADDR_LVL_G, 32'h0000_002a);
        rc(LSGB_ADDR_DIR_G, 32'h0000_0015);
        chk(32'({fOut, fOeN}), 32'h0000_a50f);
        chk(32'({gOut, gOeN}), 32'h0000_0a95);
        rc(LSGB_ADDR_LVL_F, 32'h0000_00ac);
        rc(LSGB_ADDR_LVL_G, 32'h0000_003b);
        // segment pattern with segments 33 and 36 floating
        seg <= '{14'h2b6d, 14'h0120};
        lcd_module_enable <= 1'b1;
        xfer(1'b1, LSGB_ADDR_SEN_24, 32'h0000_00f0);
        xfer(1'b1, LSGB_ADDR_SEN_32, 32'h0000_00ff);
        xfer(1'b1, LSGB_ADDR_SEN_40, 32'h0000_0003);
        rc(LSGB_ADDR_SEN_24, 32'h0000_00f0);
        chk(32'({fOut, fOeN}), {16'h0000, seg.level[3:0], seg.level[7:4], 8'h02});
        chk(32'({gOut, gOeN}), 32'h0000_0ac1);
        lcd_module_enable <= 1'b0;
        rc(LSGB_ADDR_SEN_40, 32'h0000_0003);
        chk(32'({fOut, fOeN}), 32'h0000_a50f);
        xfer(1'b1, LSGB_ADDR_DIR_F, 32'h0000_0000);
        otherReset <= 1'b1;
        @(posedge clk);
        otherReset <= 1'b0;
        rc(LSGB_ADDR_DIR_F, 32'h0000_00ff);
        rc(LSGB_ADDR_SEN_32, 32'h0000_00ff);
        xfer(1'b1, LSGB_ADDR_DIR_F, 32'h0000_0000);
        repeat (2) @(posedge clk);
        chk(32'({fOut, fOeN}), 32'h0000_a500);
        closeOut();
    end
endmodule
`default_nettype wire
